// file: design/lld_pkg.sv
// constants and types for the dram init and mode-set controller
package lld_pkg;
  // ==================================================
  // timing
  localparam int CLK_NS        = 10;
  localparam int POWER_UP_US   = 200;
  localparam int PWR_WAIT_CYC  = (POWER_UP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int MRSC_CYC_DEF  = 6;
  localparam int DLL_LOCK_CYC  = 1024;
  localparam int INIT_NOP_CNT  = 1024;
  localparam int BANK_CNT      = 8;
  localparam int DUMMY_MRS     = 2;
  localparam int ADDR_W        = 21;
  localparam int CNT_W         = 16;
  // ==================================================
  // register map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] MODE_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_DLLRST_BIT  = 1;
  localparam int STAT_ERR_BIT     = 3;
  localparam logic [8:0] MODE_RST = 9'h000;
  localparam logic [1:0] BL8_CODE = 2'h2;
  // ==================================================
  // mode word address bit positions
  localparam int A_BL0 = 3;
  localparam int A_BL1 = 4;
  localparam int A_MUX = 5;
  localparam int A_DLL = 7;
  localparam int A_IMP = 8;
  localparam int A_ODT = 9;
  // ==================================================
  // types
  typedef struct packed {
    logic       on_die_termination;
    logic       imp;
    logic       dll;
    logic       mux;
    logic [1:0] bl;
    logic [2:0] cfg;
  } lld_mode_s;

  typedef struct packed {
    logic              cs_n;
    logic              we_n;
    logic              ref_n;
    logic [2:0]        ba;
    logic [ADDR_W-1:0] addr;
  } lld_cmd_s;

  typedef struct packed {
    logic [3:0] rc;
    logic [3:0] rl;
    logic [3:0] wl;
    logic [3:0] rc_wr_rd;
  } lld_tim_s;

  localparam lld_cmd_s NOP_CMD = '{cs_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, ba: 3'h0,
                                   addr: '0};
endpackage

// file: design/lld_init_ctrl.sv
// dram power-up init and mode-register sequencer with ahb-lite control
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module lld_init_ctrl #(
  parameter int PWR_WAIT_CYC = lld_pkg::PWR_WAIT_CYC,
  parameter int MRSC_CYC     = lld_pkg::MRSC_CYC_DEF
) (
  input  wire logic             hclk,      // bus and memory command clock
  input  wire logic             hresetn,   // async reset, active low
  input  wire logic             ce,        // clock enable, freezes state when low
  input  wire logic             hsel,      // slave select
  input  wire logic [31:0]      haddr,     // byte address
  input  wire logic [1:0]       htrans,    // transfer type
  input  wire logic             hwrite,    // write when high
  input  wire logic [2:0]       hsize,     // word only
  input  wire logic [31:0]      hwdata,    // write data
  input  wire logic             hready,    // bus ready
  output logic                  hreadyout, // slave ready
  output logic                  hresp,     // always okay
  output logic [31:0]           hrdata,    // read data
  output lld_pkg::lld_cmd_s     mem_cmd    // memory command and address pins
);
  // ==================================================
  // types and functions
  typedef enum logic [3:0] {
    ST_IDLE, ST_PWR, ST_DUMMY, ST_VALID, ST_WAIT, ST_MUX_X, ST_MUX_Y,
    ST_REF, ST_NOP, ST_DONE, ST_DLL_ON
  } lld_state_e;

  function automatic lld_pkg::lld_cmd_s mrs_cmd(input logic [lld_pkg::ADDR_W-1:0] a);
    lld_pkg::lld_cmd_s c;
    c = '{cs_n: 1'b0, we_n: 1'b0, ref_n: 1'b0, ba: 3'h0, addr: a};
    return c;
  endfunction

  // non-multiplexed word, bits 10 and up stay low
  function automatic logic [lld_pkg::ADDR_W-1:0] nmx_word(
    input lld_pkg::lld_mode_s m, input logic dll, input logic mux);
    logic [lld_pkg::ADDR_W-1:0] w;
    w = '0;
    w[2:0] = m.cfg;
    w[lld_pkg::A_BL0] = m.bl[0];
    w[lld_pkg::A_BL1] = m.bl[1];
    w[lld_pkg::A_MUX] = mux;
    w[lld_pkg::A_DLL] = dll;
    w[lld_pkg::A_IMP] = m.imp;
    w[lld_pkg::A_ODT] = m.on_die_termination;
    return w;
  endfunction

  function automatic lld_pkg::lld_tim_s tim_decode(input logic [2:0] c, input logic m);
    lld_pkg::lld_tim_s t;
    logic [3:0] rc;
    case (c)
      3'h2:    rc = 4'h6;
      3'h3:    rc = 4'h8;
      3'h4:    rc = 4'h3;
      3'h5:    rc = 4'h5;
      default: rc = 4'h4;
    endcase
    t.rc = rc;
    t.rl = rc + {3'h0, m};
    t.wl = rc + 4'h1 + {3'h0, m};
    t.rc_wr_rd = (c == 3'h4) ? 4'h4 : rc;
    return t;
  endfunction

  // ==================================================
  // state
  lld_state_e                 state_ff, nxt_state, ret_ff, nxt_ret;
  logic [lld_pkg::CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic [2:0]                 bank_ff, nxt_bank;
  logic                       dll_off_ff, nxt_dll_off;
  logic                       mux_act_ff, nxt_mux_act;
  logic                       err_ff, nxt_err;
  logic                       done_ff;
  logic [10:0]                lock_cnt_ff;
  logic                       lock_run_ff, locked_ff;
  lld_pkg::lld_mode_s         mode_ff;
  lld_pkg::lld_cmd_s          cmd_ff, nxt_cmd;
  logic                       wr_pend_ff, rd_pend_ff, hready_ff;
  logic [7:0]                 wr_addr_ff, rd_addr_ff;
  logic [31:0]                hrdata_ff;

  // ==================================================
  // bus decode
  wire        acc       = hsel & hready & htrans[1];
  wire        wr_ctrl   = wr_pend_ff & (wr_addr_ff == lld_pkg::CTRL_OFF);
  wire        wr_mode   = wr_pend_ff & (wr_addr_ff == lld_pkg::MODE_OFF);
  wire        wr_stat   = wr_pend_ff & (wr_addr_ff == lld_pkg::STAT_OFF);
  wire        start_req = wr_ctrl & hwdata[lld_pkg::CTRL_START_BIT];
  wire        dll_req   = wr_ctrl & hwdata[lld_pkg::CTRL_DLLRST_BIT];
  wire        err_clr   = wr_stat & hwdata[lld_pkg::STAT_ERR_BIT];
  wire        busy      = (state_ff != ST_IDLE) & (state_ff != ST_DONE);
  wire        bl8_bad   = (mode_ff.bl == lld_pkg::BL8_CODE) &
                          ((mode_ff.cfg[2:1] == 2'h0) | (mode_ff.cfg == 3'h4));
  wire        bad_mode  = bl8_bad | (mode_ff.cfg[2:1] == 2'h3);
  wire        in_init   = (ret_ff == ST_REF) | (ret_ff == ST_MUX_X);
  wire        dll_eff   = mode_ff.dll & ~dll_off_ff;
  wire        vmux      = in_init ? mode_ff.mux : mux_act_ff;
  wire        mrs_last  = (state_ff == ST_VALID) | (state_ff == ST_MUX_Y);
  wire lld_pkg::lld_tim_s tim = tim_decode(mode_ff.cfg, mux_act_ff);
  wire [31:0] stat_word = {8'h00, tim.rc_wr_rd, tim.wl, tim.rl, tim.rc, 3'h0, mux_act_ff,
                           err_ff, locked_ff, done_ff, busy};
  wire [31:0] rd_mux    = (rd_addr_ff == lld_pkg::MODE_OFF) ? {23'h0, mode_ff} :
                          (rd_addr_ff == lld_pkg::STAT_OFF) ? stat_word : 32'h0;

  wire [lld_pkg::ADDR_W-1:0] mx_x = {{(lld_pkg::ADDR_W - 10){1'b0}}, mode_ff.on_die_termination,
                                    mode_ff.imp, 2'h0, 1'b1, mode_ff.bl, 2'h0,
                                    mode_ff.cfg[0]};
  // multiplexed second phase carries cfg high bits and dll
  wire [lld_pkg::ADDR_W-1:0] mx_y = {{(lld_pkg::ADDR_W - 8){1'b0}}, dll_eff, 2'h0,
                                    mode_ff.cfg[2:1], 3'h0};

  // ==================================================
  // sequencer
  always_comb begin
    nxt_state   = state_ff;
    nxt_ret     = ret_ff;
    nxt_cnt     = cnt_ff;
    nxt_bank    = bank_ff;
    nxt_dll_off = dll_off_ff;
    nxt_mux_act = mux_act_ff;
    // set wins over clear
    nxt_err     = err_ff & ~err_clr;
    nxt_cmd     = lld_pkg::NOP_CMD;
    case (state_ff)
      ST_IDLE: begin
        if (start_req) begin
          if (bad_mode) begin
            nxt_err = 1'b1;
          end else begin
            nxt_state = ST_PWR;
            nxt_cnt   = '0;
          end
        end
      end
      ST_PWR: begin
        if (cnt_ff == lld_pkg::CNT_W'(PWR_WAIT_CYC - 1)) begin
          nxt_state = ST_DUMMY;
          nxt_cnt   = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_DUMMY: begin
        nxt_cmd = mrs_cmd('0);
        if (cnt_ff == lld_pkg::CNT_W'(lld_pkg::DUMMY_MRS - 1)) begin
          nxt_state = ST_VALID;
          nxt_ret   = mode_ff.mux ? ST_MUX_X : ST_REF;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_VALID: begin
        nxt_cmd     = mrs_cmd(nmx_word(mode_ff, dll_eff, vmux));
        nxt_mux_act = vmux;
        nxt_state   = ST_WAIT;
        nxt_cnt     = '0;
      end
      ST_WAIT: begin
        if (cnt_ff == lld_pkg::CNT_W'(MRSC_CYC - 1)) begin
          nxt_state = ret_ff;
          nxt_cnt   = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_MUX_X: begin
        nxt_cmd   = mrs_cmd(mx_x);
        nxt_state = ST_MUX_Y;
        if (ret_ff == ST_MUX_X) begin
          nxt_ret = ST_REF;
        end
      end
      ST_MUX_Y: begin
        nxt_cmd     = mrs_cmd(mx_y);
        nxt_mux_act = 1'b1;
        nxt_state   = ST_WAIT;
        nxt_cnt     = '0;
      end
      ST_REF: begin
        nxt_cmd       = lld_pkg::NOP_CMD;
        nxt_cmd.cs_n  = 1'b0;
        nxt_cmd.ref_n = 1'b0;
        nxt_cmd.ba    = bank_ff;
        nxt_bank      = bank_ff + 3'h1;
        if (bank_ff == 3'(lld_pkg::BANK_CNT - 1)) begin
          nxt_state = ST_NOP;
          nxt_cnt   = '0;
        end
      end
      ST_NOP: begin
        if (cnt_ff == lld_pkg::CNT_W'(lld_pkg::INIT_NOP_CNT - 1)) begin
          nxt_state = ST_DONE;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_DONE: begin
        if (dll_req) begin
          nxt_dll_off = 1'b1;
          nxt_ret     = ST_DLL_ON;
          nxt_state   = mux_act_ff ? ST_MUX_X : ST_VALID;
        end
      end
      ST_DLL_ON: begin
        nxt_dll_off = 1'b0;
        nxt_ret     = ST_DONE;
        nxt_state   = mux_act_ff ? ST_MUX_X : ST_VALID;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff   <= ST_IDLE;
      ret_ff     <= ST_IDLE;
      cnt_ff     <= '0;
      bank_ff    <= 3'h0;
      dll_off_ff <= 1'b0;
      mux_act_ff <= 1'b0;
      err_ff     <= 1'b0;
      cmd_ff     <= lld_pkg::NOP_CMD;
      done_ff    <= 1'b0;
    end else if (ce) begin
      state_ff   <= nxt_state;
      ret_ff     <= nxt_ret;
      cnt_ff     <= nxt_cnt;
      bank_ff    <= nxt_bank;
      dll_off_ff <= nxt_dll_off;
      mux_act_ff <= nxt_mux_act;
      err_ff     <= nxt_err;
      cmd_ff     <= nxt_cmd;
      done_ff    <= (nxt_state == ST_DONE);
    end
  end

  // ==================================================
  // dll lock wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_cnt_ff <= 11'h000;
      lock_run_ff <= 1'b0;
      locked_ff   <= 1'b0;
    end else if (ce) begin
      if (mrs_last) begin
        lock_cnt_ff <= 11'h000;
        lock_run_ff <= dll_eff;
        locked_ff   <= 1'b0;
      end else if (lock_run_ff) begin
        lock_cnt_ff <= lock_cnt_ff + 11'h001;
        if (lock_cnt_ff == 11'(lld_pkg::DLL_LOCK_CYC - 1)) begin
          lock_run_ff <= 1'b0;
          locked_ff   <= 1'b1;
        end
      end
    end
  end

  // ==================================================
  // ahb-lite slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rd_addr_ff <= 8'h00;
      hready_ff  <= 1'b1;
      hrdata_ff  <= 32'h0;
      mode_ff    <= lld_pkg::MODE_RST;
    end else if (ce) begin
      wr_pend_ff <= acc & hwrite;
      rd_pend_ff <= acc & ~hwrite;
      if (acc) begin
        wr_addr_ff <= haddr[7:0];
        rd_addr_ff <= haddr[7:0];
      end
      hready_ff <= ~(acc & ~hwrite);
      if (rd_pend_ff) begin
        hrdata_ff <= rd_mux;
      end
      if (wr_mode & ~busy) begin
        mode_ff <= hwdata[8:0];
      end
    end
  end

  assign hreadyout = hready_ff;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign mem_cmd   = cmd_ff;

endmodule

`default_nettype wire

// file: test/lld_init_sva.sv
// concurrent checks on the init controller command and bus ports
`timescale 1ns/1ps
`default_nettype none
module lld_init_sva #(
  parameter int PWR_WAIT_CYC = 20,
  parameter int MRSC_CYC     = 2
) (
  input wire logic              hclk,      // clock
  input wire logic              hresetn,   // reset, active low
  input wire logic              ce,        // clock enable
  input wire logic              hsel,      // slave select
  input wire logic [1:0]        htrans,    // transfer type
  input wire logic              hwrite,    // write
  input wire logic              hready,    // bus ready
  input wire logic              hreadyout, // slave ready
  input wire lld_pkg::lld_cmd_s mem_cmd    // memory command
);
  wire logic   ms = !mem_cmd.cs_n && !mem_cmd.we_n && !mem_cmd.ref_n;
  wire logic   rf = !mem_cmd.cs_n && mem_cmd.we_n && !mem_cmd.ref_n;
  wire logic   np = mem_cmd.cs_n;
  wire logic   rd = hsel && hready && htrans[1] && !hwrite && ce;
  logic [15:0] gap_ff;
  logic [31:0] idle_ff;
  logic        go_ff;
  // ==========
  // helper counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_ff <= '1;
      idle_ff <= '0;
      go_ff <= 1'b0;
    end else begin
      gap_ff <= ms ? '0 : ((gap_ff == '1) ? gap_ff : gap_ff + 16'h1);
      idle_ff <= (np && !go_ff) ? idle_ff + 32'h1 : idle_ff;
      go_ff <= go_ff || !np;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========
  // assertions
  nop_form_a: assert property (np |-> mem_cmd == lld_pkg::NOP_CMD)
    else $error("idle cycle is not a clean no-operation");
  pwr_wait_a: assert property (!np && !go_ff |-> idle_ff >= PWR_WAIT_CYC)
    else $error("first command before power-up wait");
  mrs_burst_a: assert property (ms && !$past(ms) && mem_cmd.addr == '0
    |-> ##1 (ms && mem_cmd.addr == '0) ##1 ms) else $error("short mode-set burst");
  mrs_high_a: assert property (ms |-> mem_cmd.addr[20:10] == '0 && mem_cmd.ba == '0)
    else $error("mode-set high address bits not zero");
  mrs_gap_a: assert property (!np && !$past(ms) |-> gap_ff >= MRSC_CYC)
    else $error("command inside mode-set recovery");
  ref_first_a: assert property (rf && !$past(rf) |-> mem_cmd.ba == 3'h0)
    else $error("refresh run does not start at bank 0");
  ref_next_a: assert property (rf && mem_cmd.ba != 3'h7
    |=> rf && mem_cmd.ba == $past(mem_cmd.ba) + 3'h1) else $error("refresh bank order");
  ref_nop_a: assert property (rf && mem_cmd.ba == 3'h7 |=> np [*8])
    else $error("command right after refresh run");
  ay_form_a: assert property (ms && $past(ms) && $past(mem_cmd.addr[5])
    |-> (mem_cmd.addr & 21'h1fff67) == '0) else $error("second phase word bad");
  bad_mode_a: assert property (ms && $past(ms) && $past(mem_cmd.addr) == '0
    |-> !(mem_cmd.addr[4:3] == 2'h2 && mem_cmd.addr[2:0] inside {3'h0, 3'h1, 3'h4})
        && mem_cmd.addr[2:1] != 2'h3) else $error("illegal mode word issued");
  rd_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  cover property (ms ##1 ms ##1 ms);
  cover property (rf && mem_cmd.ba == 3'h7);
  cover property (ms && $past(ms) && $past(mem_cmd.addr[5]));
endmodule
bind lld_init_ctrl lld_init_sva #(.PWR_WAIT_CYC(PWR_WAIT_CYC), .MRSC_CYC(MRSC_CYC)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .mem_cmd(mem_cmd));
`default_nettype wire

// file: test/lld_dram_model.sv
// behavioural model of the memory command decoder
`timescale 1ns/1ps
`default_nettype none
module lld_dram_model #(
  parameter int PWR_WAIT_CYC = 20,
  parameter int MRSC_CYC     = 2
) (
  input  wire logic              hclk,    // command clock
  input  wire logic              hresetn, // power-on reset, active low
  input  wire lld_pkg::lld_cmd_s cmd,     // command and address pins
  output logic                   ready,   // init complete
  output logic [9:0]             mr,      // single-cycle mode word
  output logic [9:0]             ax,      // first mux phase word
  output logic [9:0]             ay,      // second mux phase word
  output int                     errs     // protocol faults seen
);
  wire logic       ms = !cmd.cs_n && !cmd.we_n && !cmd.ref_n;
  wire logic       rf = !cmd.cs_n && cmd.we_n && !cmd.ref_n;
  wire logic       np = cmd.cs_n;
  wire logic [9:0] a = cmd.addr[9:0];
  logic            mux, pms, burst;
  logic [9:0]      pa;
  logic [7:0]      banks;
  int              idle, gap, rgap, run, nops;
  wire logic f_pwr = ms && burst && run == 0 && idle < PWR_WAIT_CYC;
  wire logic f_gap = !np && !pms && gap < MRSC_CYC;
  wire logic f_busy = ms && rgap < 8;
  wire logic f_run = (ms && pms && burst && pa != '0) || (!ms && pms && burst && run < 3);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ready, mr, ax, ay, mux, pms, pa, banks} <= '0;
      {errs, idle, run, nops} <= '0;
      {gap, rgap} <= {32'd99, 32'd99};
      burst <= 1'b1;
    end else begin
      pms <= ms;
      pa <= a;
      gap <= ms ? 0 : gap + 1;
      rgap <= rf ? 0 : rgap + 1;
      if (np && burst && run == 0) idle <= idle + 1;
      if (ms && burst) run <= run + 1;
      if (!ms && pms) burst <= 1'b0;
      if (f_pwr || f_gap || f_busy || f_run) errs <= errs + 1;
      // mode capture, dll off when bit low
      if (ms && !mux) {mr, mux} <= {a, a[5]};
      if (ms && mux && pms) ay <= a;
      if (ms && mux && !pms) ax <= a;
      if (rf) banks[cmd.ba] <= 1'b1;
      if (np && &banks && nops < 1024) nops <= nops + 1;
      ready <= nops == 1024;
    end
  end
endmodule
`default_nettype wire

// file: test/lld_init_ctrl_tb.sv
// self-checking bench for the init and mode-set controller
`timescale 1ns/1ps
`default_nettype none
module lld_init_ctrl_tb;
  logic              hclk, hresetn, hsel, hwrite, rd_pend, hreadyout, hresp, ready, ce;
  logic [1:0]        htrans;
  logic [31:0]       haddr, hwdata, hrdata, rnd, v;
  logic [9:0]        mr, ax, ay;
  lld_pkg::lld_cmd_s mem_cmd;
  int                errs, failures = 0, cmp_count = 0;
  logic [31:0]       q[$];
  logic [40:0]       bad[3] = '{{9'h010, 32'h00454408}, {9'h011, 32'h00454408},
                                {9'h014, 32'h00443308}};
  lld_init_ctrl #(.PWR_WAIT_CYC(20), .MRSC_CYC(2)) dut (.hclk(hclk), .hresetn(hresetn),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mem_cmd(mem_cmd));
  lld_dram_model #(.PWR_WAIT_CYC(20), .MRSC_CYC(2)) mem (.hclk(hclk), .hresetn(hresetn),
    .cmd(mem_cmd), .ready(ready), .mr(mr), .ax(ax), .ay(ay), .errs(errs));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one single transfer; for reads d is the expected data
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    rnd = lfsr(rnd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {rnd[31:8], a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_pend <= !w;
    if (!w) q.push_back(d);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_pend <= 1'b0;
  endtask
  task automatic rst;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 3000 && ready !== 1'b1; i++) @(posedge hclk);
    repeat (4) @(posedge hclk);
    check("ready", ready, 1);
  endtask
  task automatic wait_mr(input logic [9:0] w);
    for (int i = 0; i < 400 && mr !== w; i++) @(posedge hclk);
    check("mr", mr, w);
  endtask
  always @(posedge hclk) begin
    if (rd_pend === 1'b1 && hreadyout === 1'b1) begin
      check("hrdata", hrdata, q.pop_front());
      check("hresp", {31'h0, hresp}, 32'h0);
    end
  end
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  initial begin
    {hresetn, hsel, hwrite, rd_pend, htrans, haddr, hwdata} = '0;
    ce = 1'b1;
    rnd = 32'he122;
    rst();
    // write with the clock enable low must leave the mode word alone
    ce <= 1'b0;
    ahb(1, lld_pkg::MODE_OFF, 32'h1ff);
    ce <= 1'b1;
    ahb(0, lld_pkg::MODE_OFF, 32'h0);
    ahb(0, lld_pkg::STAT_OFF, 32'h00454400);
    ahb(1, 8'h0c, rnd);
    ahb(0, 8'h0c, 32'h0);
    v = rnd;
    ahb(1, lld_pkg::MODE_OFF, v);
    ahb(0, lld_pkg::MODE_OFF, {23'h0, v[8:0]});
    foreach (bad[i]) begin
      ahb(1, lld_pkg::MODE_OFF, {23'h0, bad[i][40:32]});
      ahb(1, lld_pkg::CTRL_OFF, 32'h1);
      ahb(0, lld_pkg::STAT_OFF, bad[i][31:0]);
      ahb(1, lld_pkg::STAT_OFF, 32'h8);
    end
    ahb(0, lld_pkg::STAT_OFF, 32'h00443300);
    ahb(1, lld_pkg::MODE_OFF, 32'h0cb);
    ahb(1, lld_pkg::CTRL_OFF, 32'h1);
    ahb(0, lld_pkg::STAT_OFF, 32'h00898801);
    wait_ready();
    ahb(0, lld_pkg::STAT_OFF, 32'h00898806);
    check("mr", mr, 10'h18b);
    ahb(1, lld_pkg::CTRL_OFF, 32'h2);
    wait_mr(10'h10b);
    wait_mr(10'h18b);
    rst();
    ahb(1, lld_pkg::MODE_OFF, 32'h16c);
    ahb(1, lld_pkg::CTRL_OFF, 32'h1);
    repeat (8) @(posedge hclk);
    rst();
    ahb(1, lld_pkg::MODE_OFF, 32'h16c);
    ahb(1, lld_pkg::CTRL_OFF, 32'h1);
    wait_ready();
    ahb(0, lld_pkg::STAT_OFF, 32'h00454316);
    check("mr", mr, 10'h2ac);
    check("ax", ax, 10'h228);
    check("ay", ay, 10'h090);
    check("errs", errs, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
